// >>> core/fdc_flash_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "fdc_regs.svh"
// What this block does
// - answer only the seven bit bus address 1100111 after a start
// - eighth bit after address: 0 means write, 1 means read
// - write: first byte is register offset, next byte is stored there
// - bits with no function read back as last written; unused offsets read back as all ones
// - max current limit register 0x05 resets to 0x7f
// - led1 flash level register 0x06 resets to 0x7f
// - led1 torch level register 0x07 resets to 0x7f
// - thermistor and ramp register 0x03 resets to 0x20
// - enable bit 4 gates thermistor detection while driver active, reset 0
// - enable bit 3 enables rf sync pin and current reduction, reset 0
// - enable bit 2 enables pass mode start up sequence, reset 0
// - enable bits 1:0 mode: 00/01 standby, 10 torch, 11 flash
// - torch mode with torch pin enable clear starts torch from bus
// - flash mode with strobe pin enable clear starts flash from bus
// - monitor bits 4:3 select 2.9 to 3.2 V threshold, reset 00
// - thermistor bits 5:3 select 200 to 900 mV trip, reset 100
// - ramp bits 2:0: 000 off, else 16 ms doubling to 1024 ms
// - enable bits 7:5 select inductor current limit, reset 111
// - acknowledge on ninth clock after every byte received
// - reading first fault flag register clears all its flags except any set in the clearing cycle
module fdc_flash_regs
  import fdc_pkg::*;
#(
  parameter logic [7:0] REVISION_ID = 8'h5a // arbitrary value
) (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  output logic            o_sda,
  output logic            o_sda_oe,
  input  wire logic       i_torch_pin_en,
  input  wire logic       i_strobe_pin_en,
  input  wire logic [7:0] i_flags1_set,
  input  wire logic [7:0] i_flags2_set,
  output logic [2:0]      o_current_limit,
  output logic            o_thermistor_en,
  output logic            o_sync_en,
  output logic            o_soft_start_en,
  output logic [1:0]      o_led_mode_bits,
  output logic            o_torch_from_bus,
  output logic            o_flash_from_bus,
  output logic [1:0]      o_monitor_level,
  output logic [2:0]      o_thermistor_trip,
  output logic [2:0]      o_torch_ramp,
  output logic [7:0]      o_monitor_control,
  output logic [7:0]      o_flash_timing,
  output logic [7:0]      o_max_current_limit,
  output logic [7:0]      o_led1_flash_level,
  output logic [7:0]      o_led1_torch_level
);

  logic       rst_meta;
  logic       rst_sync;
  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic       scl_d;
  logic       sda_d;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_seen;
  logic       stop_seen;

  fdc_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] tx;
  logic       is_read;
  logic       have_ofs;
  logic [7:0] ofs;
  logic       rd_ack;
  logic       nack_seen;

  logic [7:0] driver_enable_control;
  logic [7:0] input_monitor_control;
  logic [7:0] thermistor_ramp_control;
  logic [7:0] flash_timing;
  logic [7:0] max_current_limit;
  logic [7:0] led1_flash_level;
  logic [7:0] led1_torch_level;
  logic [7:0] fault_flags_primary;
  logic [7:0] fault_flags_secondary;

  logic       wr_strobe;
  logic       rd_load;
  logic [7:0] wr_data;
  logic       next_sda_oe;

  // release retimed so every flop leaves reset on one edge
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // pins come from the master's clock world
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      scl_s <= 2'b11;
      sda_s <= 2'b11;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s <= {scl_s[0], i_scl};
      sda_s <= {sda_s[0], i_sda};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
    end
  end

  assign scl_rise   = scl_s[1] & ~scl_d;
  assign scl_fall   = ~scl_s[1] & scl_d;
  assign start_seen = scl_s[1] & scl_d & sda_d & ~sda_s[1];
  assign stop_seen  = scl_s[1] & scl_d & ~sda_d & sda_s[1];

  // unused offsets read as all ones
  function automatic logic [7:0] read_mux(input logic [7:0] a);
    case (a)
      `FDC_OFS_REV:     read_mux = REVISION_ID;
      `FDC_OFS_ENABLE:  read_mux = driver_enable_control;
      `FDC_OFS_MONITOR: read_mux = input_monitor_control;
      `FDC_OFS_THERM:   read_mux = thermistor_ramp_control;
      `FDC_OFS_TIMING:  read_mux = flash_timing;
      `FDC_OFS_MAXCUR:  read_mux = max_current_limit;
      `FDC_OFS_FLASH:   read_mux = led1_flash_level;
      `FDC_OFS_TORCH:   read_mux = led1_torch_level;
      `FDC_OFS_FLAGS1:  read_mux = fault_flags_primary;
      `FDC_OFS_FLAGS2:  read_mux = fault_flags_secondary;
      default:          read_mux = 8'hff;
    endcase
  endfunction

  function automatic logic [7:0] next_offset(input logic [7:0] a);
    next_offset = a + 8'h01;
  endfunction

  assign wr_data = {shift[6:0], sda_s[1]};

  // byte engine, samples sda on scl rise, changes sda on scl fall
  // no clock stretching: each scl phase must last at least 8 clocks
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      state     <= FDC_ST_IDLE;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      tx        <= 8'h00;
      is_read   <= 1'b0;
      have_ofs  <= 1'b0;
      ofs       <= 8'h00;
      rd_ack    <= 1'b0;
      nack_seen <= 1'b0;
      wr_strobe <= 1'b0;
      rd_load   <= 1'b0;
    end else begin
      wr_strobe <= 1'b0;
      rd_load   <= 1'b0;
      if (start_seen) begin
        state   <= FDC_ST_ADDR;
        bit_cnt <= 3'h0;
        have_ofs <= 1'b0;
      end else if (stop_seen) begin
        state <= FDC_ST_IDLE;
      end else begin
        case (state)
          FDC_ST_IDLE: begin
            bit_cnt <= 3'h0;
          end
          FDC_ST_ADDR: begin
            if (scl_rise) begin
              shift   <= wr_data;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                is_read <= sda_s[1];
                if (shift[6:0] == `FDC_DEV_ADDR) begin
                  state <= FDC_ST_AACK;
                end else begin
                  state <= FDC_ST_IDLE;
                end
              end
            end
          end
          FDC_ST_AACK, FDC_ST_WACK: begin
            // ack held from fall after 8th bit to fall after 9th
            if (scl_fall) begin
              if (rd_ack) begin
                rd_ack <= 1'b0;
                if (is_read) begin
                  state <= FDC_ST_RTX;
                  tx    <= read_mux(ofs);
                  rd_load <= 1'b1;
                end else begin
                  state <= FDC_ST_WRX;
                end
              end else begin
                rd_ack <= 1'b1;
              end
            end
          end
          FDC_ST_WRX: begin
            if (scl_rise) begin
              shift   <= wr_data;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                state <= FDC_ST_WACK;
                if (!have_ofs) begin
                  ofs      <= wr_data;
                  have_ofs <= 1'b1;
                end else begin
                  wr_strobe <= 1'b1;
                end
              end
            end
          end
          FDC_ST_RTX: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              tx      <= {tx[6:0], 1'b1};
              if (bit_cnt == 3'h7) begin
                state <= FDC_ST_RACK;
              end
            end
          end
          FDC_ST_RACK: begin
            if (scl_rise) begin
              nack_seen <= sda_s[1];
            end
            if (scl_fall) begin
              if (nack_seen) begin
                state <= FDC_ST_IDLE;
              end else begin
                ofs   <= next_offset(ofs);
                tx    <= read_mux(next_offset(ofs));
                rd_load <= 1'b1;
                state <= FDC_ST_RTX;
              end
            end
          end
          default: state <= FDC_ST_IDLE;
        endcase
      end
      // sequential writes advance the offset
      if (wr_strobe) begin
        ofs <= next_offset(ofs);
      end
    end
  end

  // ack, or a zero data bit, pulls the line low
  always_comb begin
    next_sda_oe = 1'b0;
    case (state)
      FDC_ST_AACK, FDC_ST_WACK: next_sda_oe = rd_ack;
      FDC_ST_RTX:               next_sda_oe = !tx[7];
      default:                  next_sda_oe = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      o_sda    <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      o_sda    <= 1'b0;
      o_sda_oe <= next_sda_oe;
    end
  end

  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      driver_enable_control   <= `FDC_RST_ENABLE;
      input_monitor_control   <= `FDC_RST_MONITOR;
      thermistor_ramp_control <= `FDC_RST_THERM;
      flash_timing            <= `FDC_RST_TIMING;
      max_current_limit       <= `FDC_RST_MAXCUR;
      led1_flash_level        <= `FDC_RST_FLASH;
      led1_torch_level        <= `FDC_RST_TORCH;
    end else if (wr_strobe) begin
      // writes to read-only offsets are dropped
      case (ofs)
        `FDC_OFS_ENABLE:  driver_enable_control   <= shift;
        `FDC_OFS_MONITOR: input_monitor_control   <= shift;
        `FDC_OFS_THERM:   thermistor_ramp_control <= shift;
        `FDC_OFS_TIMING:  flash_timing            <= shift;
        `FDC_OFS_MAXCUR:  max_current_limit       <= shift;
        `FDC_OFS_FLASH:   led1_flash_level        <= shift;
        `FDC_OFS_TORCH:   led1_torch_level        <= shift;
        default:          driver_enable_control   <= driver_enable_control;
      endcase
    end
  end

  // a set in the clearing cycle survives
  always_ff @(posedge i_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      fault_flags_primary   <= `FDC_RST_FLAGS1;
      fault_flags_secondary <= `FDC_RST_FLAGS2;
    end else begin
      if (rd_load && ofs == `FDC_OFS_FLAGS1) begin
        fault_flags_primary <= i_flags1_set;
      end else begin
        fault_flags_primary <= fault_flags_primary | i_flags1_set;
      end
      // upper flags2 bits hold settings, lower ones clear on read
      if (wr_strobe && ofs == `FDC_OFS_FLAGS2) begin
        fault_flags_secondary <= (shift & `FDC_FLAGS2_RW) | i_flags2_set;
      end else if (rd_load && ofs == `FDC_OFS_FLAGS2) begin
        fault_flags_secondary <= (fault_flags_secondary & `FDC_FLAGS2_RW) | i_flags2_set;
      end else begin
        fault_flags_secondary <= fault_flags_secondary | i_flags2_set;
      end
    end
  end

  assign o_current_limit  = driver_enable_control[`FDC_FLD_ILIM_HI:`FDC_FLD_ILIM_LO];
  assign o_thermistor_en  = driver_enable_control[`FDC_FLD_THERM_EN] &
                            driver_enable_control[`FDC_FLD_MODE_HI];
  assign o_sync_en        = driver_enable_control[`FDC_FLD_SYNC_EN];
  assign o_soft_start_en  = driver_enable_control[`FDC_FLD_SOFT_EN];
  assign o_led_mode_bits  = driver_enable_control[`FDC_FLD_MODE_HI:`FDC_FLD_MODE_LO];
  assign o_torch_from_bus = (fdc_mode_t'(o_led_mode_bits) == FDC_MODE_TORCH) &&
                            !i_torch_pin_en;
  assign o_flash_from_bus = (fdc_mode_t'(o_led_mode_bits) == FDC_MODE_FLASH) &&
                            !i_strobe_pin_en;
  assign o_monitor_level  = input_monitor_control[`FDC_FLD_MON_HI:`FDC_FLD_MON_LO];
  assign o_thermistor_trip = thermistor_ramp_control[`FDC_FLD_TRIP_HI:`FDC_FLD_TRIP_LO];
  assign o_torch_ramp     = thermistor_ramp_control[`FDC_FLD_RAMP_HI:`FDC_FLD_RAMP_LO];
  assign o_monitor_control   = input_monitor_control;
  assign o_flash_timing      = flash_timing;
  assign o_max_current_limit = max_current_limit;
  assign o_led1_flash_level  = led1_flash_level;
  assign o_led1_torch_level  = led1_torch_level;

endmodule
`default_nettype wire

// >>> core/fdc_regs.svh
`ifndef FDC_REGS_SVH
`define FDC_REGS_SVH
`define FDC_DEV_ADDR      7'h67
`define FDC_OFS_REV       8'h00
`define FDC_OFS_ENABLE    8'h01
`define FDC_OFS_MONITOR   8'h02
`define FDC_OFS_THERM     8'h03
`define FDC_OFS_TIMING    8'h04
`define FDC_OFS_MAXCUR    8'h05
`define FDC_OFS_FLASH     8'h06
`define FDC_OFS_TORCH     8'h07
`define FDC_OFS_FLAGS1    8'h08
`define FDC_OFS_FLAGS2    8'h09
`define FDC_RST_ENABLE    8'he0
`define FDC_RST_MONITOR   8'ha4
`define FDC_RST_THERM     8'h20
`define FDC_RST_TIMING    8'h42
`define FDC_RST_MAXCUR    8'h7f
`define FDC_RST_FLASH     8'h7f
`define FDC_RST_TORCH     8'h7f
`define FDC_RST_FLAGS1    8'h00
`define FDC_RST_FLAGS2    8'h30
`define FDC_FLD_ILIM_HI   7
`define FDC_FLD_ILIM_LO   5
`define FDC_FLD_THERM_EN  4
`define FDC_FLD_SYNC_EN   3
`define FDC_FLD_SOFT_EN   2
`define FDC_FLD_MODE_HI   1
`define FDC_FLD_MODE_LO   0
`define FDC_FLD_MON_HI    4
`define FDC_FLD_MON_LO    3
`define FDC_FLD_TRIP_HI   5
`define FDC_FLD_TRIP_LO   3
`define FDC_FLD_RAMP_HI   2
`define FDC_FLD_RAMP_LO   0
`define FDC_FLAGS2_RW     8'hf0
`endif

// >>> core/fdc_pkg.sv
package fdc_pkg;
  typedef enum logic [1:0] {
    FDC_MODE_OFF0  = 2'b00,
    FDC_MODE_OFF1  = 2'b01,
    FDC_MODE_TORCH = 2'b10,
    FDC_MODE_FLASH = 2'b11
  } fdc_mode_t;
  typedef enum logic [2:0] {
    FDC_ST_IDLE  = 3'b000,
    FDC_ST_ADDR  = 3'b001,
    FDC_ST_AACK  = 3'b010,
    FDC_ST_WRX   = 3'b011,
    FDC_ST_WACK  = 3'b100,
    FDC_ST_RTX   = 3'b101,
    FDC_ST_RACK  = 3'b110
  } fdc_state_t;
endpackage

// >>> test/fdc_flash_regs_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module fdc_flash_regs_monitor (
  input wire logic       i_clk,
  input wire logic       i_rstn,
  input wire logic       i_scl,
  input wire logic       i_torch_pin_en,
  input wire logic       i_strobe_pin_en,
  input wire logic       o_sda,
  input wire logic       o_sda_oe,
  input wire logic [2:0] o_current_limit,
  input wire logic       o_thermistor_en,
  input wire logic       o_sync_en,
  input wire logic       o_soft_start_en,
  input wire logic [1:0] o_led_mode_bits,
  input wire logic       o_torch_from_bus,
  input wire logic       o_flash_from_bus,
  input wire logic [1:0] o_monitor_level,
  input wire logic [2:0] o_thermistor_trip,
  input wire logic [2:0] o_torch_ramp,
  input wire logic [7:0] o_max_current_limit,
  input wire logic [7:0] o_led1_flash_level,
  input wire logic [7:0] o_led1_torch_level
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_torch_bus_start: assert property (o_torch_from_bus == (o_led_mode_bits == 2'b10 && !i_torch_pin_en))
    else $error("torch bus start mismatch");
  a_flash_bus_start: assert property (o_flash_from_bus == (o_led_mode_bits == 2'b11 && !i_strobe_pin_en))
    else $error("flash bus start mismatch");
  a_therm_gate: assert property (o_thermistor_en |-> o_led_mode_bits[1])
    else $error("thermistor enabled while driver idle");
  a_open_drain: assert property (o_sda_oe |-> o_sda == 1'b0)
    else $error("data line driven high");
  // bus data may only move while the clock line is low
  a_ack_timing: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data line changed while clock high");
  a_reset_levels: assert property ($rose(i_rstn) |-> o_max_current_limit == 8'h7f && o_led1_flash_level == 8'h7f && o_led1_torch_level == 8'h7f)
    else $error("level registers not at defaults");
  a_reset_therm: assert property ($rose(i_rstn) |-> o_thermistor_trip == 3'b100 && o_torch_ramp == 3'b000)
    else $error("thermistor ramp register not at default");
  a_reset_enable: assert property ($rose(i_rstn) |-> o_current_limit == 3'b111 && !o_sync_en && !o_soft_start_en && o_led_mode_bits == 2'b00 && !o_thermistor_en)
    else $error("enable register not at default");
  a_reset_monitor: assert property ($rose(i_rstn) |-> o_monitor_level == 2'b00)
    else $error("monitor threshold not at default");
  c_ack: cover property ($rose(o_sda_oe));
  c_torch: cover property (o_torch_from_bus);
  c_flash: cover property (o_flash_from_bus);
endmodule
`default_nettype wire

// >>> test/fdc_i2c_host.sv
`timescale 1ns/10ps
`default_nettype none
module fdc_i2c_host #(
  parameter int H = 10
) (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var logic  o_scl,
  output var logic  o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic hold();
    repeat (H) @(posedge i_clk);
  endtask
  // data only changes while the clock is low
  task automatic put(input logic b);
    o_sda_low <= !b;
    hold();
    o_scl <= 1'b1;
    hold();
    o_scl <= 1'b0;
    hold();
  endtask
  task automatic get(output logic b);
    o_sda_low <= 1'b0;
    hold();
    o_scl <= 1'b1;
    hold();
    b = i_sda;
    o_scl <= 1'b0;
    hold();
  endtask
  // also serves as repeated start
  task automatic start();
    o_sda_low <= 1'b0;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda_low <= 1'b1;
    hold();
    o_scl <= 1'b0;
    hold();
  endtask
  task automatic stop();
    o_sda_low <= 1'b1;
    hold();
    o_scl <= 1'b1;
    hold();
    o_sda_low <= 1'b0;
    hold();
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put(d[i]);
    get(a);
    ack = !a;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic last);
    for (int i = 7; i >= 0; i--) get(d[i]);
    put(last);
  endtask
endmodule
`default_nettype wire

// >>> test/fdc_flash_regs_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fdc_regs.svh"
`define CHK(g, e) chk(8'(g), 8'(e))
module fdc_flash_regs_tb_top;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic i_clk, i_rstn, tp, sp, scl, h_low, oe, sda_o;
  logic [7:0] f1, f2;
  wire logic sda = !(h_low | oe);
  int error_cnt = 0;
  int cmp_count = 0;
  fdc_i2c_host u_host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(h_low));
  fdc_flash_regs #(.REVISION_ID(REV)) DUT (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda), .o_sda(sda_o), .o_sda_oe(oe),
    .i_torch_pin_en(tp), .i_strobe_pin_en(sp), .i_flags1_set(f1), .i_flags2_set(f2),
    .o_current_limit(), .o_thermistor_en(), .o_sync_en(), .o_soft_start_en(),
    .o_led_mode_bits(), .o_torch_from_bus(), .o_flash_from_bus(), .o_monitor_level(),
    .o_thermistor_trip(), .o_torch_ramp(), .o_monitor_control(), .o_flash_timing(),
    .o_max_current_limit(), .o_led1_flash_level(), .o_led1_torch_level());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [6:0] id, input logic [7:0] ofs, d, output logic ok);
    logic a0, a1, a2;
    u_host.start();
    u_host.wbyte({id, 1'b0}, a0);
    u_host.wbyte(ofs, a1);
    u_host.wbyte(d, a2);
    u_host.stop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    u_host.start();
    u_host.wbyte({`FDC_DEV_ADDR, 1'b0}, a);
    u_host.wbyte(ofs, a);
    u_host.start();
    u_host.wbyte({`FDC_DEV_ADDR, 1'b1}, a);
    `CHK(a, 1'b1);
    u_host.rbyte(d, 1'b1);
    u_host.stop();
  endtask
  task automatic t_reset();
    logic [7:0] exp [11] = '{REV, 8'he0, 8'ha4, 8'h20, 8'h42, 8'h7f, 8'h7f, 8'h7f,
                             8'h00, 8'h30, 8'hff};
    logic [7:0] d;
    `CHK(sda_o, 1'b0);
    `CHK(DUT.o_monitor_control, 8'ha4);
    `CHK(DUT.o_max_current_limit, 8'h7f);
    `CHK(DUT.o_led1_flash_level, 8'h7f);
    `CHK(DUT.o_led1_torch_level, 8'h7f);
    for (int i = 0; i < 11; i++) begin
      rd(8'(i), d);
      `CHK(d, exp[i]);
    end
  endtask
  task automatic t_enable();
    logic [7:0] v, d;
    logic ok;
    for (int m = 0; m < 4; m++) begin
      v = {3'(m), m[1], m[0], !m[0], 2'(m)};
      wr(`FDC_DEV_ADDR, `FDC_OFS_ENABLE, v, ok);
      `CHK(ok, 1'b1);
      `CHK(DUT.o_current_limit, m);
      `CHK({DUT.o_thermistor_en, DUT.o_sync_en, DUT.o_soft_start_en}, {m[1], m[0], !m[0]});
      `CHK(DUT.o_led_mode_bits, m);
      for (int p = 0; p < 2; p++) begin
        tp <= p[0];
        sp <= p[0];
        repeat (2) @(posedge i_clk);
        `CHK(DUT.o_torch_from_bus, m == 2 && p == 0);
        `CHK(DUT.o_flash_from_bus, m == 3 && p == 0);
      end
      rd(`FDC_OFS_ENABLE, d);
      `CHK(d, v);
    end
  endtask
  task automatic t_refuse();
    logic ok;
    logic [7:0] d;
    // neighbour address must stay silent
    wr(7'h66, `FDC_OFS_MAXCUR, 8'h11, ok);
    `CHK(ok, 1'b0);
    wr(`FDC_DEV_ADDR, `FDC_OFS_REV, 8'h00, ok);
    rd(`FDC_OFS_REV, d);
    `CHK(d, REV);
    rd(`FDC_OFS_MAXCUR, d);
    `CHK(d, 8'h7f);
  endtask
  task automatic t_fields();
    logic ok;
    logic [7:0] d;
    wr(`FDC_DEV_ADDR, `FDC_OFS_MONITOR, 8'h18, ok);
    `CHK(DUT.o_monitor_level, 2'b11);
    `CHK(DUT.o_monitor_control, 8'h18);
    wr(`FDC_DEV_ADDR, `FDC_OFS_THERM, 8'h3e, ok);
    `CHK({DUT.o_thermistor_trip, DUT.o_torch_ramp}, 6'h3e);
    rd(`FDC_OFS_THERM, d);
    `CHK(d, 8'h3e);
    wr(`FDC_DEV_ADDR, `FDC_OFS_TIMING, 8'h9c, ok);
    `CHK(DUT.o_flash_timing, 8'h9c);
    wr(`FDC_DEV_ADDR, `FDC_OFS_FLASH, 8'h35, ok);
    `CHK(DUT.o_led1_flash_level, 8'h35);
    wr(`FDC_DEV_ADDR, `FDC_OFS_TORCH, 8'h4b, ok);
    `CHK(DUT.o_led1_torch_level, 8'h4b);
    wr(`FDC_DEV_ADDR, `FDC_OFS_MAXCUR, 8'h12, ok);
    `CHK(DUT.o_max_current_limit, 8'h12);
  endtask
  task automatic t_flags();
    logic [7:0] d;
    logic ok;
    f1 <= 8'h44;
    f2 <= 8'h06;
    @(posedge i_clk);
    f1 <= 8'h01;
    f2 <= 8'h00;
    // a set held across the clearing read must survive it
    rd(`FDC_OFS_FLAGS1, d);
    `CHK(d, 8'h45);
    f1 <= 8'h00;
    rd(`FDC_OFS_FLAGS1, d);
    `CHK(d, 8'h01);
    rd(`FDC_OFS_FLAGS1, d);
    `CHK(d, 8'h00);
    rd(`FDC_OFS_FLAGS2, d);
    `CHK(d, 8'h36);
    rd(`FDC_OFS_FLAGS2, d);
    `CHK(d, 8'h30);
    wr(`FDC_DEV_ADDR, `FDC_OFS_FLAGS2, 8'haf, ok);
    `CHK(ok, 1'b1);
    rd(`FDC_OFS_FLAGS2, d);
    `CHK(d, 8'ha0);
  endtask
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = !i_clk;
  end
  initial begin
    i_rstn = 1'b0;
    tp = 1'b0;
    sp = 1'b0;
    f1 = 8'h00;
    f2 = 8'h00;
    repeat (3) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (6) @(posedge i_clk);
    t_reset();
    t_enable();
    t_refuse();
    t_fields();
    t_flags();
    complete_run();
  end
  // run needs about 40k cycles
  initial begin
    #1_400_000;
    error_cnt++;
    complete_run();
  end
endmodule
bind fdc_flash_regs fdc_flash_regs_monitor u_mon (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_scl(i_scl), .i_torch_pin_en(i_torch_pin_en),
  .i_strobe_pin_en(i_strobe_pin_en), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
  .o_current_limit(o_current_limit), .o_thermistor_en(o_thermistor_en),
  .o_sync_en(o_sync_en), .o_soft_start_en(o_soft_start_en),
  .o_led_mode_bits(o_led_mode_bits), .o_torch_from_bus(o_torch_from_bus),
  .o_flash_from_bus(o_flash_from_bus), .o_monitor_level(o_monitor_level),
  .o_thermistor_trip(o_thermistor_trip), .o_torch_ramp(o_torch_ramp),
  .o_max_current_limit(o_max_current_limit), .o_led1_flash_level(o_led1_flash_level),
  .o_led1_torch_level(o_led1_torch_level));
`default_nettype wire
